// [mol_pkg.sv]
// Purpose: Shared constants and types for the motor overload thermal model.
// Assumes: Content values are in tenths of a percent (0..1000 = 0..100.0 %).
// Notes: Register offsets are byte addresses on a 32-bit AXI4-Lite slave.
package mol_pkg;

  // ---------------------------------------------------------------
  // Content scale
  // ---------------------------------------------------------------
  localparam logic [9:0] MOL_FULL = 10'd1000;
  localparam logic [9:0] MOL_BIAS_TOP = 10'd999;
  localparam logic [9:0] MOL_DISABLED_CAP = 10'd990;
  localparam logic [9:0] MOL_MARGIN_NUM = 10'd5;
  localparam logic [9:0] MOL_MARGIN_DEN = 10'd4;
  localparam int MOL_START_HISTORY = 4;
  localparam int MOL_COOL_TAU_DIV = 5;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int MOL_CLK_HZ = 100_000_000;
  localparam int MOL_TICK_MS = 100;
  localparam int MOL_TICK_CYCLES = MOL_CLK_HZ / 1000 * MOL_TICK_MS;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] MOL_REG_CTRL = 8'h00;
  localparam logic [7:0] MOL_REG_CLASS = 8'h04;
  localparam logic [7:0] MOL_REG_BIAS = 8'h08;
  localparam logic [7:0] MOL_REG_COOL = 8'h0C;
  localparam logic [7:0] MOL_REG_CONTENT = 8'h10;
  localparam logic [7:0] MOL_REG_LOCKOUT = 8'h14;
  localparam logic [7:0] MOL_REG_IRQ_STAT = 8'h18;
  localparam logic [7:0] MOL_REG_IRQ_MASK = 8'h1C;

  // Control register fields.
  localparam int MOL_CTRL_INDEP_BIT = 0;
  localparam int MOL_CTRL_EMRST_BIT = 1;
  localparam int MOL_CTRL_HC_LSB = 8;
  // Class register fields: a class of zero means Off.
  localparam int MOL_CLASS_START_LSB = 0;
  localparam int MOL_CLASS_RUN_LSB = 8;
  // Bias temperature fields, degrees C.
  localparam int MOL_BIAS_MIN_LSB = 0;
  localparam int MOL_BIAS_MID_LSB = 10;
  localparam int MOL_BIAS_MAX_LSB = 20;
  // Interrupt status bits.
  localparam int MOL_IRQ_BIAS = 0;
  localparam int MOL_IRQ_EMRST = 1;
  localparam int MOL_IRQ_LOCK = 2;
  localparam int MOL_IRQ_START = 3;

  // Reset values.
  localparam logic [31:0] MOL_CTRL_RST = 32'h0002_5800;
  localparam logic [31:0] MOL_CLASS_RST = 32'h0000_0A0A;
  localparam logic [31:0] MOL_BIAS_RST = 32'h0962_0828;
  localparam logic [31:0] MOL_COOL_RST = 32'h0000_0708;

  typedef enum logic [2:0] {
    MOL_STOPPED,
    MOL_KICK,
    MOL_ACCEL,
    MOL_RUN_PRE_UTS,
    MOL_RUN_UTS,
    MOL_DECEL
  } mol_phase_t;

  typedef struct packed {
    logic [9:0] current_pct;
    logic [9:0] derate_pct;
    logic [9:0] stator_temp;
    mol_phase_t phase;
    logic [9:0] heat_step;
  } mol_meas_t;

  function automatic logic [9:0] mol_min10(input logic [9:0] a, input logic [9:0] b);
    mol_min10 = (a < b) ? a : b;
  endfunction

endpackage

// [mol_bias_calc.sv]
// Purpose: Maps the hottest stator temperature to a bias thermal value.
// Assumes: Temperatures in degrees C, ratio and result in tenths of a percent.
// Notes: Combinational; the division is sized for a single tick of settling.
`timescale 1ns/1ps
module mol_bias_calc
  import mol_pkg::*;
(
  input wire logic [9:0] temp_in,
  input wire logic [9:0] bias_min_temperature_in,
  input wire logic [9:0] bias_mid_temperature_in,
  input wire logic [9:0] bias_max_temperature_in,
  input wire logic [9:0] hot_to_cold_ratio_in,
  output logic [9:0] bias_thermal_value_out
);

  logic [19:0] num;
  logic [9:0] span;
  logic [19:0] quo;

  always_comb begin
    num = 20'd0;
    span = 10'd1;
    bias_thermal_value_out = 10'd0;
    if (temp_in < bias_min_temperature_in) begin
      bias_thermal_value_out = 10'd0;
    end else if (temp_in < bias_mid_temperature_in) begin
      num = (temp_in - bias_min_temperature_in) * hot_to_cold_ratio_in;
      span = bias_mid_temperature_in - bias_min_temperature_in;
      bias_thermal_value_out = quo[9:0];
    end else if (temp_in <= bias_max_temperature_in && bias_max_temperature_in != bias_mid_temperature_in) begin
      num = (temp_in - bias_mid_temperature_in) * (MOL_BIAS_TOP - hot_to_cold_ratio_in);
      span = bias_max_temperature_in - bias_mid_temperature_in;
      bias_thermal_value_out = 10'(quo[9:0] + hot_to_cold_ratio_in);
    end else begin
      bias_thermal_value_out = MOL_BIAS_TOP;
    end
  end

  assign quo = (span == 10'd0) ? 20'd0 : num / {10'd0, span};

endmodule

// [mol_start_history.sv]
// Purpose: Remembers the content used by recent successful starts.
// Assumes: start_done_in pulses once per successful start with its usage.
// Notes: An empty history gives a release level of full content.
`timescale 1ns/1ps
module mol_start_history
  import mol_pkg::*;
#(
  parameter int DEPTH = MOL_START_HISTORY
)
(
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire logic start_done_in,
  input wire logic [9:0] start_used_in,
  output logic [9:0] release_level_out
);

  logic [9:0] hist_q [DEPTH];
  logic [12:0] sum;
  logic [12:0] need;

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      for (int i = 0; i < DEPTH; i++) begin
        hist_q[i] <= 10'd0;
      end
    end else if (start_done_in) begin
      hist_q[0] <= start_used_in;
      for (int i = 1; i < DEPTH; i++) begin
        hist_q[i] <= hist_q[i-1];
      end
    end
  end

  always_comb begin
    sum = 13'd0;
    for (int i = 0; i < DEPTH; i++) begin
      sum = sum + {3'd0, hist_q[i]};
    end
    // Average then apply the 1.25 margin; one division keeps rounding in one place.
    need = 13'((16'(sum) * 16'(MOL_MARGIN_NUM)) / (16'(MOL_MARGIN_DEN) * 16'(DEPTH)));
    release_level_out = (need >= {3'd0, MOL_FULL}) ? 10'd0 : 10'(MOL_FULL - need[9:0]);
  end

endmodule

// [mol_thermal_model.sv]
// Purpose: Motor overload content model with biasing, cooling, lockout and reset.
// Assumes: Measurements are synchronous to clk_sys_in; heat_step comes from the curve logic.
// Notes: Content updates once per periodic tick; registers on AXI4-Lite.
//
// Functional notes
// - Content takes the bias value only when the bias value exceeds content.
// - Below the minimum bias temperature the bias value is zero.
// - Min to mid: fractional position times the hot-to-cold ratio.
// - Mid to max: linear from the hot-to-cold ratio up to 99.9 percent.
// - Above the maximum bias temperature the bias value is 99.9 percent.
// - Release level is full minus 1.25 times the four-start average; block until below.
// - Without independent selection the running class applies in every phase.
// - Independent: starting class until up-to-speed, running class afterwards and in deceleration.
// - Changing class keeps the accumulated content unchanged.
// - With the active class Off, content is clamped to at most 99 percent.
// - Hot-to-cold tracking continues while a class is Off.
// - With both classes Off, content is forced to zero.
// - Stopped content decays exponentially at rate five over the cooling time.
// - The cooling time is the decay from full content to under one percent.
// - Running above steady state cools with time scaled by current over derate.
// - Emergency reset clears content and lockout but not a latched fault.
// - Emergency reset comes from keypad chord, digital input or control bit.
//
// Added by the designer: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
module mol_thermal_model
  import mol_pkg::*;
#(
  parameter int TICK_CYCLES = MOL_TICK_CYCLES,
  parameter int START_DEPTH = MOL_START_HISTORY
)
(
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire mol_meas_t meas_in,
  input wire logic key_reset_in,
  input wire logic key_down_in,
  input wire logic din_emergency_reset_in,
  input wire logic start_done_in,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [9:0] content_out,
  output logic start_lockout_out,
  output logic active_class_off_out,
  output logic irq_out
);

  // ---------------------------------------------------------------
  // Registers and state
  // ---------------------------------------------------------------
  logic [31:0] ctrl_q;
  logic [31:0] class_q;
  logic [31:0] bias_q;
  logic [31:0] cool_q;
  logic [3:0] irq_stat_q;
  logic [3:0] irq_mask_q;
  logic [9:0] content_q;
  logic [9:0] content_d;
  logic [9:0] start_base_q;
  logic lock_q;
  logic [31:0] tick_cnt_q;
  logic tick;
  logic [7:0] awaddr_q;
  logic aw_held_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic w_held_q;
  logic wr_fire;
  logic emrst_req;
  logic [9:0] bias_val;
  logic [9:0] release_level;
  logic [3:0] irq_events;

  // ---------------------------------------------------------------
  // Decoded settings
  // ---------------------------------------------------------------
  logic independent_class_select;
  logic [7:0] starting_overload_class;
  logic [7:0] running_overload_class;
  logic [9:0] hot_to_cold_ratio;
  logic [15:0] cooling_time_setting;
  logic [7:0] active_class;
  logic both_off;
  logic starting_phase;

  assign independent_class_select = ctrl_q[MOL_CTRL_INDEP_BIT];
  assign hot_to_cold_ratio = ctrl_q[MOL_CTRL_HC_LSB +: 10];
  assign starting_overload_class = class_q[MOL_CLASS_START_LSB +: 8];
  assign running_overload_class = class_q[MOL_CLASS_RUN_LSB +: 8];
  assign cooling_time_setting = cool_q[15:0];

  assign starting_phase = (meas_in.phase == MOL_KICK) || (meas_in.phase == MOL_ACCEL) ||
                          (meas_in.phase == MOL_RUN_PRE_UTS);
  // The class pick only selects the curve; content is never rescaled on a change.
  assign active_class = (independent_class_select && starting_phase) ? starting_overload_class
                                                                   : running_overload_class;
  assign both_off = independent_class_select ? (starting_overload_class == 8'h00 &&
                    running_overload_class == 8'h00) : (running_overload_class == 8'h00);

  assign emrst_req = (key_reset_in && key_down_in) || din_emergency_reset_in ||
                     ctrl_q[MOL_CTRL_EMRST_BIT];

  // ---------------------------------------------------------------
  // Submodules
  // ---------------------------------------------------------------
  mol_bias_calc u_bias (
    .temp_in(meas_in.stator_temp),
    .bias_min_temperature_in(bias_q[MOL_BIAS_MIN_LSB +: 10]),
    .bias_mid_temperature_in(bias_q[MOL_BIAS_MID_LSB +: 10]),
    .bias_max_temperature_in(bias_q[MOL_BIAS_MAX_LSB +: 10]),
    .hot_to_cold_ratio_in(hot_to_cold_ratio),
    .bias_thermal_value_out(bias_val)
  );

  mol_start_history #(.DEPTH(START_DEPTH)) u_hist (
    .clk_sys_in(clk_sys_in),
    .srst_in(srst_in),
    .start_done_in(start_done_in),
    .start_used_in(content_q > start_base_q ? 10'(content_q - start_base_q) : 10'd0),
    .release_level_out(release_level)
  );

  // ---------------------------------------------------------------
  // Update tick
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (srst_in || tick) begin
      tick_cnt_q <= 32'd0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'd1;
    end
  end
  assign tick = (tick_cnt_q == 32'(TICK_CYCLES - 1));

  // ---------------------------------------------------------------
  // Thermal update
  // ---------------------------------------------------------------
  function automatic logic [9:0] mol_decay(input logic [9:0] val, input logic [9:0] target,
                                           input logic [31:0] tau_ticks);
    logic [31:0] diff;
    logic [31:0] step;
    begin
      diff = 32'(val - target);
      step = (tau_ticks == 32'd0) ? diff : diff / tau_ticks;
      if (step == 32'd0 && diff != 32'd0) begin
        step = 32'd1;
      end
      mol_decay = 10'(32'(val) - step);
    end
  endfunction

  logic [9:0] ol_ss;
  logic [31:0] tau_stop;
  logic [31:0] tau_run;
  logic [9:0] thermal;

  always_comb begin
    ol_ss = 10'(({10'd0, hot_to_cold_ratio} * {10'd0, meas_in.current_pct}) / 20'd100 * 20'd100 /
            ((meas_in.derate_pct == 10'd0) ? 20'd100 : {10'd0, meas_in.derate_pct}));
    // Settings in seconds; tau is a fifth of the cooling time, expressed in ticks.
    tau_stop = 32'(cooling_time_setting) * 32'(1000 / MOL_TICK_MS) / 32'(MOL_COOL_TAU_DIV);
    tau_run = tau_stop * 32'(meas_in.current_pct) /
              ((meas_in.derate_pct == 10'd0) ? 32'd100 : 32'(meas_in.derate_pct));
    thermal = content_q;
    if (meas_in.phase == MOL_STOPPED) begin
      thermal = mol_decay(content_q, 10'd0, tau_stop);
    end else if (content_q > ol_ss) begin
      thermal = mol_decay(content_q, ol_ss, tau_run);
    end else if (content_q < ol_ss) begin
      thermal = 10'(content_q + 10'd1);
    end
    if (meas_in.phase != MOL_STOPPED && active_class != 8'h00) begin
      // Sum in eleven bits so a large step saturates at full instead of wrapping.
      if ({1'b0, thermal} + {1'b0, meas_in.heat_step} >= {1'b0, MOL_FULL}) begin
        thermal = MOL_FULL;
      end else begin
        thermal = 10'(thermal + meas_in.heat_step);
      end
    end
    if (bias_val > thermal) begin
      thermal = bias_val;
    end
    content_d = thermal;
    if (active_class == 8'h00) begin
      content_d = mol_min10(content_d, MOL_DISABLED_CAP);
    end
    if (emrst_req || both_off) begin
      content_d = 10'd0;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      content_q <= 10'd0;
    end else if (tick) begin
      content_q <= content_d;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      start_base_q <= 10'd0;
    end else if (meas_in.phase == MOL_STOPPED) begin
      start_base_q <= content_q;
    end
  end

  // Lockout sets when content reaches the release level and clears once below it.
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      lock_q <= 1'b0;
    end else if (emrst_req) begin
      lock_q <= 1'b0;
    end else if (tick) begin
      lock_q <= (content_d >= release_level);
    end
  end

  assign content_out = content_q;
  assign start_lockout_out = lock_q;
  assign active_class_off_out = (active_class == 8'h00);

  // ---------------------------------------------------------------
  // Interrupts
  // ---------------------------------------------------------------
  assign irq_events[MOL_IRQ_BIAS] = tick && (bias_val > content_q);
  assign irq_events[MOL_IRQ_EMRST] = tick && emrst_req;
  assign irq_events[MOL_IRQ_LOCK] = tick && !lock_q && (content_d >= release_level);
  assign irq_events[MOL_IRQ_START] = start_done_in;

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      irq_stat_q <= 4'h0;
    end else begin
      // A new event wins over a write-one-to-clear in the same cycle.
      irq_stat_q <= (irq_stat_q & ~((wr_fire && awaddr_q == MOL_REG_IRQ_STAT && wstrb_q[0]) ?
                    wdata_q[3:0] : 4'h0)) | irq_events;
    end
  end
  assign irq_out = |(irq_stat_q & irq_mask_q);

  // ---------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------
  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready = !w_held_q && !s_axi_bvalid;
  assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  function automatic logic [31:0] mol_merge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      old[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
    mol_merge = old;
  endfunction

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      ctrl_q <= MOL_CTRL_RST;
      class_q <= MOL_CLASS_RST;
      bias_q <= MOL_BIAS_RST;
      cool_q <= MOL_COOL_RST;
      irq_mask_q <= 4'h0;
      s_axi_bresp <= 2'b00;
    end else if (wr_fire) begin
      s_axi_bresp <= 2'b00;
      case (awaddr_q)
        MOL_REG_CTRL: ctrl_q <= mol_merge(ctrl_q, wdata_q, wstrb_q);
        MOL_REG_CLASS: class_q <= mol_merge(class_q, wdata_q, wstrb_q);
        MOL_REG_BIAS: bias_q <= mol_merge(bias_q, wdata_q, wstrb_q);
        MOL_REG_COOL: cool_q <= mol_merge(cool_q, wdata_q, wstrb_q);
        MOL_REG_IRQ_MASK: irq_mask_q <= wstrb_q[0] ? wdata_q[3:0] : irq_mask_q;
        MOL_REG_IRQ_STAT, MOL_REG_CONTENT, MOL_REG_LOCKOUT: s_axi_bresp <= 2'b00;
        default: s_axi_bresp <= 2'b10;
      endcase
    end
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'b00;
      case (s_axi_araddr)
        MOL_REG_CTRL: s_axi_rdata <= ctrl_q;
        MOL_REG_CLASS: s_axi_rdata <= class_q;
        MOL_REG_BIAS: s_axi_rdata <= bias_q;
        MOL_REG_COOL: s_axi_rdata <= cool_q;
        MOL_REG_CONTENT: s_axi_rdata <= {22'd0, content_q};
        MOL_REG_LOCKOUT: s_axi_rdata <= {21'd0, lock_q, release_level};
        MOL_REG_IRQ_STAT: s_axi_rdata <= {28'd0, irq_stat_q};
        MOL_REG_IRQ_MASK: s_axi_rdata <= {28'd0, irq_mask_q};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'b10;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// [mol_thermal_model_chk.sv]
// Purpose: Port-level assertions for the overload content model.
// Assumes: One clock domain with a synchronous active-high reset.
// Notes: Attached to every model instance by the bind at the foot.
`timescale 1ns/1ps
module mol_thermal_model_chk
  import mol_pkg::*;
#(
  parameter int TICK_CYCLES = MOL_TICK_CYCLES
)
(
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire logic din_emergency_reset_in,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [9:0] content_out,
  input wire logic start_lockout_out,
  input wire logic active_class_off_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (srst_in);
  // A held request must reach zero content within two ticks, whatever the tick phase.
  int unsigned em_wait_q;
  always_ff @(posedge clk_sys_in) begin
    if (srst_in || !din_emergency_reset_in || content_out == 10'h000) begin
      em_wait_q <= 0;
    end else begin
      em_wait_q <= em_wait_q + 1;
    end
  end
  sequence rd_taken_s;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence wr_taken_s;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  rd_answer_a: assert property (rd_taken_s |=> s_axi_rvalid) else $error("read late");
  wr_answer_a: assert property (wr_taken_s |-> ##[1:2] s_axi_bvalid) else $error("write late");
  resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
  busy_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("taken busy");
  reset_clear_a: assert property ($past(srst_in) |-> content_out == 10'h000 && !start_lockout_out)
    else $error("reset left state");
  lockout_clear_a: assert property (din_emergency_reset_in |=> !start_lockout_out) else $error("lockout kept");
  off_clamp_a: assert property ($changed(content_out) && active_class_off_out && $past(active_class_off_out)
    |-> content_out <= MOL_DISABLED_CAP) else $error("content above cap");
  emergency_zero_a: assert property (em_wait_q <= 2 * TICK_CYCLES + 1) else $error("reset slow");
endmodule
bind mol_thermal_model mol_thermal_model_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.clk_sys_in(clk_sys_in),
  .srst_in(srst_in), .din_emergency_reset_in(din_emergency_reset_in), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .content_out(content_out),
  .start_lockout_out(start_lockout_out), .active_class_off_out(active_class_off_out));

// [mol_plant_model.sv]
// Purpose: Stands in for current and temperature sensing and the keypad.
// Assumes: The bench changes temperature, phase and reset source after a rising edge.
// Notes: Full-load current, no imbalance and no curve heating, so only biasing and steady-state tracking move content up.
`timescale 1ns/1ps
module mol_plant_model
  import mol_pkg::*;
(
  input wire logic [9:0] temp_in,
  input wire mol_phase_t phase_in,
  input wire logic [1:0] reset_src_in,
  output mol_meas_t meas_out,
  output logic key_reset_out,
  output logic key_down_out,
  output logic din_emergency_reset_out
);
  // Source 1 is the two-key chord, source 2 the digital input.
  assign meas_out = '{10'h064, 10'h064, temp_in, phase_in, 10'h000};
  assign key_reset_out = reset_src_in == 2'h1;
  assign key_down_out = reset_src_in == 2'h1;
  assign din_emergency_reset_out = reset_src_in == 2'h2;
endmodule

// [mol_thermal_model_tb.sv]
// Purpose: Self-checking bench for the overload content model.
// Assumes: A short update tick so that thermal steps finish quickly.
// Notes: Outputs are sampled at the falling edge, where they are settled.
`timescale 1ns/1ps
module mol_thermal_model_tb;
  import mol_pkg::*;
  localparam int TK = 20;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [9:0] temp = 10'h014;
  mol_phase_t phase = MOL_STOPPED;
  logic [1:0] src = 2'h0;
  logic sdone = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq, lock, coff, kr, kd, din;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] rdata, rd;
  logic [9:0] content;
  mol_meas_t meas;
  int fail_count = 0;
  int checks = 0;
  logic [7:0] ra [6] = '{MOL_REG_CTRL, MOL_REG_CLASS, MOL_REG_BIAS, MOL_REG_COOL, MOL_REG_LOCKOUT, 8'h40};
  logic [31:0] re [6] = '{MOL_CTRL_RST, MOL_CLASS_RST, MOL_BIAS_RST, MOL_COOL_RST, 32'h0000_03E8, 32'h0};
  logic [9:0] bt [3] = '{10'h055, 10'h082, 10'h08C};
  logic [9:0] be [3] = '{10'h12C, 10'h258, 10'h31F};
  initial begin
    forever #5 clk = ~clk;
  end
  mol_plant_model plant (.temp_in(temp), .phase_in(phase), .reset_src_in(src), .meas_out(meas),
    .key_reset_out(kr), .key_down_out(kd), .din_emergency_reset_out(din));
  mol_thermal_model #(.TICK_CYCLES(TK)) dut (.clk_sys_in(clk), .srst_in(srst), .meas_in(meas),
    .key_reset_in(kr), .key_down_in(kd), .din_emergency_reset_in(din), .start_done_in(sdone),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .content_out(content), .start_lockout_out(lock),
    .active_class_off_out(coff), .irq_out(irq));
  task automatic report_and_stop();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic hang();
    fail_count++;
    report_and_stop();
  endtask
  // Looks at the falling edge, so the next rising edge is the one that samples the handshake.
  task automatic edge_until(ref logic s);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
      if (n > 60) hang();
    end while (s !== 1'b1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw;
    int n;
    n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      if (n++ > 60) hang();
      @(negedge clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end while (awvalid || wvalid);
    @(posedge clk);
    bready <= 1'b1;
    edge_until(bvalid);
    chk({30'h0, bresp}, 32'h0);
    @(posedge clk);
    bready <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    edge_until(arready);
    @(posedge clk);
    arvalid <= 1'b0;
    @(posedge clk);
    rready <= 1'b1;
    edge_until(rvalid);
    rd = rdata;
    rs = rresp;
    @(posedge clk);
    rready <= 1'b0;
  endtask
  task automatic ticks(input int k);
    repeat (k * TK) @(posedge clk);
    @(negedge clk);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    foreach (ra[i]) begin
      rd_reg(ra[i]);
      chk(rd, re[i]);
      chk({30'h0, rs}, (ra[i] == 8'h40) ? 32'h2 : 32'h0);
    end
    $display("test defaults done");
    wr(MOL_REG_IRQ_MASK, 32'h2);
    @(posedge clk);
    temp <= 10'h0C8;
    ticks(3);
    chk(content, 10'h3E7);
    chk(irq, 1'b0);
    for (int s = 0; s < 3; s++) begin
      @(posedge clk);
      temp <= 10'h0C8;
      ticks(2);
      chk(content, 10'h3E7);
      @(posedge clk);
      temp <= 10'h014;
      if (s == 2) wr(MOL_REG_CTRL, MOL_CTRL_RST | 32'h2);
      else src <= 2'(s + 1);
      ticks(2);
      chk(content, 10'h000);
      chk(lock, 1'b0);
      chk(irq, 1'b1);
      @(posedge clk);
      src <= 2'h0;
      wr(MOL_REG_CTRL, MOL_CTRL_RST);
      wr(MOL_REG_IRQ_STAT, 32'h2);
      ticks(0);
      chk(irq, 1'b0);
    end
    $display("test emergency reset done");
    ticks(1);
    chk(content, 10'h000);
    foreach (bt[i]) begin
      @(posedge clk);
      temp <= bt[i];
      ticks(2);
      chk(32'(content >= be[i] && content <= be[i] + 10'h001), 32'h1);
    end
    $display("test bias curve done");
    wr(MOL_REG_CLASS, 32'h0000_000A);
    for (int m = 0; m < 2; m++) begin
      wr(MOL_REG_CTRL, MOL_CTRL_RST | 32'(m));
      for (int p = 1; p < 6; p++) begin
        @(posedge clk);
        phase <= mol_phase_t'(p);
        ticks(0);
        chk(coff, m == 0 || p > 3);
      end
    end
    @(posedge clk);
    temp <= 10'h0C8;
    phase <= MOL_RUN_UTS;
    ticks(2);
    chk(content, MOL_DISABLED_CAP);
    wr(MOL_REG_CLASS, 32'h0);
    ticks(2);
    chk(content, 10'h000);
    $display("test class selection done");
    @(posedge clk);
    phase <= MOL_STOPPED;
    @(posedge clk);
    phase <= MOL_RUN_UTS;
    wr(MOL_REG_CLASS, 32'h0000_0A0A);
    ticks(2);
    @(posedge clk);
    sdone <= 1'b1;
    @(posedge clk);
    sdone <= 1'b0;
    ticks(1);
    chk(lock, 1'b1);
    rd_reg(MOL_REG_LOCKOUT);
    chk(rd, 32'h0000_06B0);
    $display("test start lockout done");
    report_and_stop();
  end
endmodule
